// ---- common/aodr_pkg.sv ----
// Purpose: Shared constants of the analog output diagnostic record.
// Assumes: 100 MHz clock, record read one byte per request.
// Notes:   Byte positions count from the summary byte at position 0.
package aodr_pkg;
    // Timing
    localparam int US_PERIOD_NS  = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_CYCLES     = US_PERIOD_NS / CLK_PERIOD_NS;
    localparam int STAMP_W       = 32;

    // Access kinds on the request port
    localparam logic [1:0] ACC_RECORD_SET = 2'h0;
    localparam logic [1:0] ACC_CAN_INDEX  = 2'h1;
    localparam logic [1:0] ACC_OBJ_SUBIDX = 2'h2;

    // Record selectors and lengths
    localparam logic [7:0]  SET_SHORT   = 8'h00;
    localparam logic [7:0]  SET_FULL    = 8'h01;
    localparam logic [15:0] CAN_SHORT   = 16'h2f00;
    localparam logic [15:0] CAN_FULL    = 16'h2f01;
    localparam logic [15:0] OBJ_INDEX   = 16'h5005;
    localparam logic [7:0]  SUB_FIRST   = 8'h02;
    localparam logic [7:0]  SUB_LAST    = 8'h11;
    localparam logic [7:0]  SUB_STAMP   = 8'h13;
    localparam logic [4:0]  LEN_FULL    = 5'h14;
    localparam logic [4:0]  LEN_SHORT   = 5'h04;
    localparam logic [4:0]  LEN_STAMP   = 5'h04;

    // Byte positions inside the record
    localparam logic [4:0] BYTE_SUMMARY  = 5'h00;
    localparam logic [4:0] BYTE_MODINFO  = 5'h01;
    localparam logic [4:0] BYTE_RSVD_C   = 5'h02;
    localparam logic [4:0] BYTE_INTERNAL = 5'h03;
    localparam logic [4:0] BYTE_CHKIND   = 5'h04;
    localparam logic [4:0] BYTE_BITS     = 5'h05;
    localparam logic [4:0] BYTE_CHCOUNT  = 5'h06;
    localparam logic [4:0] BYTE_GROUPS   = 5'h07;
    localparam logic [4:0] BYTE_CHAN0    = 5'h08;
    localparam logic [4:0] BYTE_STAMP    = 5'h10;

    // Constant bytes
    localparam logic [7:0] MODULE_INFO_VAL  = 8'h15;
    localparam logic [7:0] CHANNEL_KIND_VAL = 8'h73;
    localparam logic [7:0] BITS_PER_CH_VAL  = 8'h08;
    localparam logic [7:0] CH_COUNT_VAL     = 8'h02;
    localparam int         NUM_CH           = 2;

    // Bit positions
    localparam int SUM_MODULE_FAIL = 0;
    localparam int SUM_INTERNAL    = 1;
    localparam int SUM_EXTERNAL    = 2;
    localparam int SUM_CHANNEL     = 3;
    localparam int SUM_AUX_MISSING = 4;
    localparam int SUM_PARAM       = 7;
    localparam int INT_OVERFLOW    = 3;
    localparam int INT_COMM        = 4;
    localparam int CHE_PARAM       = 0;
    localparam int CHE_SHORT       = 3;
endpackage : aodr_pkg

// ---- common/aodr_tick_if.sv ----
// Purpose: Carries the microsecond ticker to the record logic.
// Assumes: One clock domain.
// Notes:   us_tick is high in the cycle the count has just stepped.
interface aodr_tick_if;
    logic [31:0] us_count;
    logic        us_tick;
    modport ticker (output us_count, output us_tick);
    modport user   (input us_count, input us_tick);
endinterface : aodr_tick_if

// ---- verilog/aodr_us_ticker.sv ----
// Purpose: Free-running 32-bit microsecond counter.
// Assumes: clk_i at the rate of the package timing constants.
// Notes:   Wraps silently after the maximum count.
module aodr_us_ticker #(
    parameter int CYCLES_PER_US = aodr_pkg::US_CYCLES
) (
    input  wire logic   clk_i,
    input  wire logic   sys_rst_i,
    aodr_tick_if.ticker tick
);
    localparam int PW = $clog2(CYCLES_PER_US + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(CYCLES_PER_US - 1);

    typedef struct packed {
        logic [PW-1:0] pre;
        logic [31:0]   count;
        logic          pulse;
    } aodr_tick_state_type;

    aodr_tick_state_type s_q;
    aodr_tick_state_type s_d;

    always_comb begin
        s_d       = s_q;
        s_d.pulse = 1'b0;
        if (s_q.pre == PRE_LAST) begin
            s_d.pre   = '0;
            s_d.count = s_q.count + 32'h0000_0001;
            s_d.pulse = 1'b1;
        end else begin
            s_d.pre = s_q.pre + PW'(1);
        end
    end

    // Power-on clears the count
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick.us_count = s_q.count;
    assign tick.us_tick  = s_q.pulse;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_tick_step: assert property (s_q.pulse |-> s_q.count == $past(s_q.count) + 32'h1)
        else $error("ticker did not step by one");
    a_tick_hold: assert property (!s_d.pulse |=> $stable(s_q.count))
        else $error("ticker moved between ticks");
    a_tick_wrap: assert property (s_q.count == 32'hffff_ffff && s_d.pulse |=> s_q.count == 32'h0)
        else $error("ticker did not wrap to zero");
    c_tick_seen: cover property (s_q.pulse);
endmodule : aodr_us_ticker

// ---- verilog/aodr_diag_record.sv ----
// Purpose: Read-only diagnostic record of a two-channel analog output module.
// Assumes: Error inputs synchronous to clk_i; one byte read per request.
// Notes:   Answer is registered on the same edge that takes the request.
// What this block does
// - No diagnostic interrupt; diagnostics are only readable record contents.
// - A channel error lights that channel's LED and enters the record.
// - Report parameter errors and short-circuits, the latter only when enabled.
// - Record set 01h returns the full record, 00h only the first 4 bytes.
// - Index 2F01h returns the full record, 2F00h only the first 4 bytes.
// - Object index 5005h exposes one byte per subindex from 02h to 11h, and the 4 stamp bytes at 13h.
// - Summary byte flags failure, internal, external, channel, supply, parameter.
// - Internal byte: bit 3 buffer overflow, bit 4 communication error.
// - Module information byte reads 15h: analog class with channel info.
// - Channel kind byte reads 73h, analog output.
// - Diagnostic bits per channel reads constant 08h.
// - Channel count reads constant 02h.
// - Channel group byte: bit 0 group 0, bit 1 group 1, rest zero.
// - Per-channel byte: bit 0 parameter error, bit 3 short to ground.
// - Recording a diagnostic event captures the microsecond ticker.
// - Microsecond counter starts at zero at power-on, steps every microsecond.
// - Counter is 32 bits and wraps to zero after its maximum.
module aodr_diag_record #(
    parameter int CYCLES_PER_US = aodr_pkg::US_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        module_fail_i,
    input  wire logic        internal_err_i,
    input  wire logic        external_err_i,
    input  wire logic        aux_supply_missing_i,
    input  wire logic        diag_overflow_i,
    input  wire logic        comm_err_i,
    input  wire logic [1:0]  chan_param_err_i,
    input  wire logic [1:0]  chan_short_i,
    input  wire logic [1:0]  short_enable_i,
    input  wire logic        req_valid_i,
    input  wire logic [1:0]  req_access_i,
    input  wire logic [7:0]  record_set_number_i,
    input  wire logic [15:0] object_index_i,
    input  wire logic [7:0]  object_subindex_i,
    input  wire logic [4:0]  req_byte_i,
    output logic             rsp_valid_o,
    output logic             rsp_error_o,
    output logic [7:0]       rsp_data_o,
    output logic [1:0]       chan_led_o
);
    typedef struct packed {
        logic [7:0]       summary;
        logic [7:0]       internal;
        logic [1:0][7:0]  chan_err;
        logic [31:0]      stamp;
        logic             rsp_valid;
        logic             rsp_error;
        logic [7:0]       rsp_data;
    } aodr_rec_state_type;

    aodr_rec_state_type s_q;
    aodr_rec_state_type s_d;

    aodr_tick_if tick ();

    aodr_us_ticker #(
        .CYCLES_PER_US (CYCLES_PER_US)
    ) u_ticker (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .tick      (tick)
    );

    logic [7:0] group_byte;
    logic       hit;
    logic [4:0] idx;
    logic [4:0] lim;
    logic [7:0] sel_byte;
    logic [63:0] err_old;
    logic [63:0] err_new;

    // Group bits follow any bit of the per-channel byte
    always_comb begin
        group_byte = '0;
        for (int c = 0; c < aodr_pkg::NUM_CH; c++) begin
            group_byte[c] = |s_q.chan_err[c];
        end
    end

    // Request decode into a byte position of the record
    always_comb begin
        hit = 1'b0;
        idx = req_byte_i;
        lim = aodr_pkg::LEN_FULL;
        if (req_access_i == aodr_pkg::ACC_RECORD_SET) begin
            if (record_set_number_i == aodr_pkg::SET_FULL) begin
                hit = 1'b1;
            end else if (record_set_number_i == aodr_pkg::SET_SHORT) begin
                hit = 1'b1;
                lim = aodr_pkg::LEN_SHORT;
            end
        end else if (req_access_i == aodr_pkg::ACC_CAN_INDEX) begin
            if (object_index_i == aodr_pkg::CAN_FULL) begin
                hit = 1'b1;
            end else if (object_index_i == aodr_pkg::CAN_SHORT) begin
                hit = 1'b1;
                lim = aodr_pkg::LEN_SHORT;
            end
        end else if (req_access_i == aodr_pkg::ACC_OBJ_SUBIDX) begin
            lim = 5'h01;
            if (object_index_i != aodr_pkg::OBJ_INDEX) begin
                hit = 1'b0;
            end else if (object_subindex_i >= aodr_pkg::SUB_FIRST &&
                         object_subindex_i <= aodr_pkg::SUB_LAST) begin
                // One byte per subindex, summary at the first
                hit = 1'b1;
                idx = 5'(object_subindex_i - aodr_pkg::SUB_FIRST);
            end else if (object_subindex_i == aodr_pkg::SUB_STAMP) begin
                hit = 1'b1;
                lim = aodr_pkg::LEN_STAMP;
                idx = aodr_pkg::BYTE_STAMP + req_byte_i;
            end
        end
        // Byte position beyond the selected object
        if (req_byte_i >= lim) begin
            hit = 1'b0;
        end
    end

    // Byte content of the record
    always_comb begin
        sel_byte = 8'h00;
        if (idx == aodr_pkg::BYTE_SUMMARY) begin
            sel_byte = s_q.summary;
        end else if (idx == aodr_pkg::BYTE_MODINFO) begin
            sel_byte = aodr_pkg::MODULE_INFO_VAL;
        end else if (idx == aodr_pkg::BYTE_RSVD_C) begin
            sel_byte = 8'h00;
        end else if (idx == aodr_pkg::BYTE_INTERNAL) begin
            sel_byte = s_q.internal;
        end else if (idx == aodr_pkg::BYTE_CHKIND) begin
            sel_byte = aodr_pkg::CHANNEL_KIND_VAL;
        end else if (idx == aodr_pkg::BYTE_BITS) begin
            sel_byte = aodr_pkg::BITS_PER_CH_VAL;
        end else if (idx == aodr_pkg::BYTE_CHCOUNT) begin
            sel_byte = aodr_pkg::CH_COUNT_VAL;
        end else if (idx == aodr_pkg::BYTE_GROUPS) begin
            sel_byte = group_byte;
        end else if (idx == aodr_pkg::BYTE_CHAN0) begin
            sel_byte = s_q.chan_err[0];
        end else if (idx == aodr_pkg::BYTE_CHAN0 + 5'h01) begin
            sel_byte = s_q.chan_err[1];
        end else if (idx >= aodr_pkg::BYTE_STAMP) begin
            // Least significant byte first
            sel_byte = s_q.stamp[8*(idx - aodr_pkg::BYTE_STAMP) +: 8];
        end
    end

    // Next state: error bytes, event stamp, answer
    always_comb begin
        s_d = s_q;
        s_d.internal = '0;
        s_d.internal[aodr_pkg::INT_OVERFLOW] = diag_overflow_i;
        s_d.internal[aodr_pkg::INT_COMM]     = comm_err_i;
        for (int c = 0; c < aodr_pkg::NUM_CH; c++) begin
            s_d.chan_err[c] = '0;
            s_d.chan_err[c][aodr_pkg::CHE_PARAM] = chan_param_err_i[c];
            // Short is ignored while detection is off
            s_d.chan_err[c][aodr_pkg::CHE_SHORT] =
                chan_short_i[c] & short_enable_i[c];
        end
        s_d.summary = '0;
        s_d.summary[aodr_pkg::SUM_MODULE_FAIL] = module_fail_i;
        s_d.summary[aodr_pkg::SUM_INTERNAL]    = internal_err_i | (|s_d.internal);
        s_d.summary[aodr_pkg::SUM_EXTERNAL]    = external_err_i;
        s_d.summary[aodr_pkg::SUM_CHANNEL]     = |s_d.chan_err;
        s_d.summary[aodr_pkg::SUM_AUX_MISSING] = aux_supply_missing_i;
        s_d.summary[aodr_pkg::SUM_PARAM]       = |chan_param_err_i;
        // Stamp only on a newly raised bit, so clearing keeps the event time
        if (|(err_new & ~err_old)) begin
            s_d.stamp = tick.us_count;
        end
        s_d.rsp_valid = req_valid_i;
        s_d.rsp_error = req_valid_i & ~hit;
        s_d.rsp_data  = (req_valid_i && hit) ? sel_byte : 8'h00;
    end

    // Inputs to the capture decision
    assign err_old = {s_q.summary, s_q.internal, s_q.chan_err, 32'h0000_0000};
    assign err_new = {s_d.summary, s_d.internal, s_d.chan_err, 32'h0000_0000};

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // No interrupt line exists; state is only read out
    assign rsp_valid_o = s_q.rsp_valid;
    assign rsp_error_o = s_q.rsp_error;
    assign rsp_data_o  = s_q.rsp_data;
    assign chan_led_o  = group_byte[1:0];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence rec_read(logic [4:0] b);
        req_valid_i && req_access_i == aodr_pkg::ACC_RECORD_SET &&
        record_set_number_i == aodr_pkg::SET_FULL && req_byte_i == b;
    endsequence

    a_led_on_error: assert property ($rose(chan_param_err_i[0]) |=> chan_led_o[0])
        else $error("channel 0 LED not lit on error");
    a_short_gated: assert property (chan_short_i[1] && !short_enable_i[1] &&
        !chan_param_err_i[1] |=> !chan_led_o[1] && !s_q.chan_err[1][3])
        else $error("short reported while detection off");
    a_short_set_len: assert property (req_valid_i && req_access_i == aodr_pkg::ACC_RECORD_SET
        && record_set_number_i == aodr_pkg::SET_SHORT && req_byte_i >= 5'h04
        |=> rsp_valid_o && rsp_error_o)
        else $error("short record set served a byte past four");
    a_can_full_len: assert property (req_valid_i && req_access_i == aodr_pkg::ACC_CAN_INDEX
        && object_index_i == aodr_pkg::CAN_FULL && req_byte_i == 5'h13
        |=> rsp_valid_o && !rsp_error_o)
        else $error("full index refused its last byte");
    a_subidx_kind: assert property (req_valid_i && req_access_i == aodr_pkg::ACC_OBJ_SUBIDX
        && object_index_i == aodr_pkg::OBJ_INDEX && object_subindex_i == 8'h06
        && req_byte_i == 5'h00 |=> rsp_data_o == 8'h73 && !rsp_error_o)
        else $error("subindex 06h did not return channel kind");
    a_summary_rsvd: assert property (rec_read(5'h00) |=> rsp_data_o[6:5] == 2'b00)
        else $error("summary reserved bits set");
    a_summary_chan: assert property (rec_read(5'h00) && s_q.chan_err != '0
        |=> rsp_data_o[3])
        else $error("summary channel bit missing");
    a_internal_bits: assert property (rec_read(5'h03) |=> rsp_data_o[7:5] == 3'b000 &&
        rsp_data_o[2:0] == 3'b000)
        else $error("internal byte reserved bits set");
    a_module_info: assert property (rec_read(5'h01) |=> rsp_data_o == 8'h15)
        else $error("module info byte wrong");
    a_bits_per_ch: assert property (rec_read(5'h05) |=> rsp_data_o == 8'h08)
        else $error("bits per channel wrong");
    a_chan_count: assert property (rec_read(5'h06) |=> rsp_data_o == 8'h02)
        else $error("channel count wrong");
    a_group_rsvd: assert property (rec_read(5'h07) |=> rsp_data_o[7:2] == 6'h00)
        else $error("group byte reserved bits set");
    a_chan_rsvd: assert property (rec_read(5'h08) |=> rsp_data_o[2:1] == 2'b00 &&
        rsp_data_o[7:4] == 4'h0)
        else $error("channel byte reserved bits set");
    a_stamp_take: assert property ($rose(chan_param_err_i[1]) && !s_q.chan_err[1][0]
        |=> s_q.stamp == $past(tick.us_count))
        else $error("event time not captured");

    c_full_read: cover property (rec_read(5'h13));
    c_short_seen: cover property (s_q.chan_err[0][3]);
    c_stamp_read: cover property (req_valid_i && object_subindex_i == aodr_pkg::SUB_STAMP);
endmodule : aodr_diag_record

// ---- bench/aodr_host_model.sv ----
// Purpose: Backplane reader model that fetches diagnostic record bytes.
// Assumes: Answer stands right after the taking edge and is read 1 ns later.
// Notes:   Released request fields show inverted values, never stale ones.
module aodr_host_model (
    input  wire logic        clk_i,
    output logic             req_valid_o,
    output logic [1:0]       req_access_o,
    output logic [7:0]       record_set_number_o,
    output logic [15:0]      object_index_o,
    output logic [7:0]       object_subindex_o,
    output logic [4:0]       req_byte_o,
    input  wire logic        rsp_valid_i,
    input  wire logic        rsp_error_i,
    input  wire logic [7:0]  rsp_data_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req_valid_o         = 1'b0;
        req_access_o        = 2'h0;
        record_set_number_o = 8'h00;
        object_index_o      = 16'h0000;
        object_subindex_o   = 8'h00;
        req_byte_o          = 5'h00;
    end

    // Caller picks set, index or subindex through acc
    task automatic read_byte(input logic [1:0] acc, input logic [7:0] set,
                             input logic [15:0] idx, input logic [7:0] sub,
                             input logic [4:0] pos, output logic v, output logic e,
                             output logic [7:0] d);
        @(posedge clk_i);
        req_valid_o         <= 1'b1;
        req_access_o        <= acc;
        record_set_number_o <= set;
        object_index_o      <= idx;
        object_subindex_o   <= sub;
        req_byte_o          <= pos;
        @(posedge clk_i);
        req_valid_o         <= 1'b0;
        req_access_o        <= ~acc;
        record_set_number_o <= ~set;
        object_index_o      <= ~idx;
        object_subindex_o   <= ~sub;
        req_byte_o          <= ~pos;
        #1;
        v = rsp_valid_i;
        e = rsp_error_i;
        d = rsp_data_i;
    endtask : read_byte
endmodule : aodr_host_model

// ---- bench/aodr_diag_record_tb_top.sv ----
// Purpose: Self-checking bench of the diagnostic record.
// Assumes: Ticker shortened to 4 cycles per microsecond.
// Notes:   Timestamps are checked by difference, immune to ticker phase.
module aodr_diag_record_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CPU = 4;
    logic clk_i = 0, sys_rst_i = 1, module_fail_i = 0, internal_err_i = 0, external_err_i = 0;
    logic aux_supply_missing_i = 0, diag_overflow_i = 0, comm_err_i = 0;
    logic [1:0]  chan_param_err_i = 0, chan_short_i = 0, short_enable_i = 0, chan_led_o;
    logic req_valid_i, rsp_valid_o, rsp_error_o;
    logic [1:0]  req_access_i;
    logic [7:0]  record_set_number_i, object_subindex_i, rsp_data_o;
    logic [15:0] object_index_i;
    logic [4:0]  req_byte_i;
    logic [7:0]  exp_rec [0:15];
    logic [31:0] stamp_a, stamp_b;
    int n_mismatch = 0, check_count = 0, cyc = 0, cyc_a;

    always #5 clk_i = ~clk_i;

    aodr_diag_record #(.CYCLES_PER_US(CPU)) i_aodr_diag_record (.*);
    aodr_host_model i_aodr_host_model (.clk_i(clk_i), .req_valid_o(req_valid_i),
        .req_access_o(req_access_i), .record_set_number_o(record_set_number_i),
        .object_index_o(object_index_i), .object_subindex_o(object_subindex_i),
        .req_byte_o(req_byte_i), .rsp_valid_i(rsp_valid_o), .rsp_error_i(rsp_error_o),
        .rsp_data_i(rsp_data_o));

    task conclude;
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // Bounded run; a hang counts against the verdict
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_mismatch++;
            $display("mismatch at %0t: timeout", $time);
            conclude();
        end
    end

    task cmp(input logic [7:0] got, input logic [7:0] want, input string what);
        check_count++;
        if (got !== want) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, want);
        end
    endtask : cmp

    task rd(input logic [1:0] acc, input logic [7:0] set, input logic [15:0] idx,
            input logic [7:0] sub, input int pos, input logic err, input logic [7:0] want);
        logic v, e;
        logic [7:0] d;
        i_aodr_host_model.read_byte(acc, set, idx, sub, 5'(pos), v, e, d);
        cmp({6'h00, v, e}, {6'h00, 1'b1, err}, "valid and error");
        cmp(d, err ? 8'h00 : want, "read data");
    endtask : rd

    task check_all(input string name);
        for (int i = 0; i < 16; i++) begin
            rd(aodr_pkg::ACC_RECORD_SET, 8'h01, 0, 0, i, 0, exp_rec[i]);
            rd(aodr_pkg::ACC_CAN_INDEX, 0, 16'h2f01, 0, i, 0, exp_rec[i]);
            rd(aodr_pkg::ACC_OBJ_SUBIDX, 0, 16'h5005, 8'h02 + 8'(i), 0, 0, exp_rec[i]);
        end
        for (int i = 0; i < 4; i++) begin
            rd(aodr_pkg::ACC_RECORD_SET, 8'h00, 0, 0, i, 0, exp_rec[i]);
            rd(aodr_pkg::ACC_CAN_INDEX, 0, 16'h2f00, 0, i, 0, exp_rec[i]);
        end
        $display("test %s done", name);
    endtask : check_all

    task read_stamp(output logic [31:0] s);
        logic v, e;
        logic [7:0] d;
        for (int k = 0; k < 4; k++) begin
            i_aodr_host_model.read_byte(aodr_pkg::ACC_RECORD_SET, 8'h01, 0, 0, 5'(16 + k), v, e, d);
            s[8*k+:8] = d;
            rd(aodr_pkg::ACC_OBJ_SUBIDX, 0, 16'h5005, 8'h13, k, 0, d);
            rd(aodr_pkg::ACC_CAN_INDEX, 0, 16'h2f01, 0, 16 + k, 0, d);
        end
    endtask : read_stamp

    initial begin
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        foreach (exp_rec[i]) exp_rec[i] = 8'h00;
        exp_rec[1] = 8'h15;
        exp_rec[4] = 8'h73;
        exp_rec[5] = 8'h08;
        exp_rec[6] = 8'h02;
        check_all("reset values");
        read_stamp(stamp_a);
        cmp(stamp_a[7:0] | stamp_a[15:8] | stamp_a[23:16] | stamp_a[31:24], 0, "stamp");
        // Unmapped selectors and lengths must be refused
        rd(aodr_pkg::ACC_RECORD_SET, 8'h00, 0, 0, 4, 1, 0);
        rd(aodr_pkg::ACC_RECORD_SET, 8'h01, 0, 0, 20, 1, 0);
        rd(aodr_pkg::ACC_RECORD_SET, 8'h02, 0, 0, 0, 1, 0);
        rd(aodr_pkg::ACC_CAN_INDEX, 0, 16'h2f00, 0, 4, 1, 0);
        rd(aodr_pkg::ACC_CAN_INDEX, 0, 16'h2f02, 0, 0, 1, 0);
        rd(2'h3, 8'h01, 0, 0, 0, 1, 0);
        rd(aodr_pkg::ACC_OBJ_SUBIDX, 0, 16'h5004, 8'h02, 0, 1, 0);
        rd(aodr_pkg::ACC_OBJ_SUBIDX, 0, 16'h5005, 8'h01, 0, 1, 0);
        rd(aodr_pkg::ACC_OBJ_SUBIDX, 0, 16'h5005, 8'h12, 0, 1, 0);
        rd(aodr_pkg::ACC_OBJ_SUBIDX, 0, 16'h5005, 8'h14, 0, 1, 0);
        rd(aodr_pkg::ACC_OBJ_SUBIDX, 0, 16'h5005, 8'h02, 1, 1, 0);
        rd(aodr_pkg::ACC_OBJ_SUBIDX, 0, 16'h5005, 8'h13, 4, 1, 0);
        $display("test refusals done");
        // One module condition at a time: summary byte and internal byte
        for (int k = 0; k < 6; k++) begin
            @(posedge clk_i);
            {comm_err_i, diag_overflow_i, aux_supply_missing_i, external_err_i,
             internal_err_i, module_fail_i} <= 6'(1 << k);
            rd(aodr_pkg::ACC_RECORD_SET, 8'h01, 0, 0, 0, 0,
               k < 4 ? 8'(1 << (k == 3 ? 4 : k)) : 8'h02);
            rd(aodr_pkg::ACC_RECORD_SET, 8'h01, 0, 0, 3, 0, k < 4 ? 8'h00 : 8'(8 << (k - 4)));
        end
        @(posedge clk_i);
        {comm_err_i, diag_overflow_i, aux_supply_missing_i, external_err_i} <= 4'h0;
        $display("test module conditions done");
        chan_param_err_i <= 2'b01;
        repeat (2) @(posedge clk_i);
        cmp(8'(chan_led_o), 8'h01, "channel led");
        exp_rec[0] = 8'h88;
        exp_rec[7] = 8'h01;
        exp_rec[8] = 8'h01;
        check_all("parameter error");
        chan_param_err_i <= 2'b00;
        chan_short_i     <= 2'b10;
        exp_rec[0] = 8'h00;
        exp_rec[7] = 8'h00;
        exp_rec[8] = 8'h00;
        check_all("short not enabled");
        cmp(8'(chan_led_o), 8'h00, "channel led");
        short_enable_i <= 2'b10;
        repeat (2) @(posedge clk_i);
        cmp(8'(chan_led_o), 8'h02, "channel led");
        exp_rec[0] = 8'h08;
        exp_rec[7] = 8'h02;
        exp_rec[9] = 8'h08;
        check_all("short enabled");
        // Two events exactly ten microseconds apart
        chan_short_i <= 2'b00;
        repeat (4) @(posedge clk_i);
        chan_param_err_i <= 2'b10;
        cyc_a = cyc;
        read_stamp(stamp_a);
        while (cyc < cyc_a + 10 * CPU) @(posedge clk_i);
        chan_param_err_i <= 2'b11;
        read_stamp(stamp_b);
        cmp(8'(stamp_b - stamp_a), 8'h0a, "stamp step");
        cmp(8'((stamp_b - stamp_a) >> 8), 8'h00, "stamp step high");
        chan_param_err_i <= 2'b00;
        read_stamp(stamp_a);
        cmp(8'(stamp_a ^ stamp_b) | 8'((stamp_a ^ stamp_b) >> 8), 8'h00, "stamp held");
        $display("test timestamp done");
        conclude();
    end
endmodule : aodr_diag_record_tb_top
